// file: verilog/rt_command_validation_config.sv
// Configuration registers and command validation for a 1553 remote terminal
// Notes on behaviour
// - Undefined codes: 0-15,16,18,19 rx; 17,20,21 tx
// - Bit 3 clear: undefined codes valid, table decides
// - Illegal mode: error status; status only if directed
// - Bit 3 set: undefined codes ignored, no status
// - Bit 2 set: broadcast data in separate buffer
// - Bit 1 set: simplified mode handling for valid codes
// - Host sets bit 0 before any byte readback
// - Master reset clears all configuration bits
// - Second 16-bit register at 0x0001, survives soft reset
// - Address 31 is broadcast unless broadcast disabled
`timescale 1ns/1ps
`include "rt_cmd_cfg.svh"

module rt_command_validation_config (
  // Clock, master reset and soft reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic soft_reset,
  // Host register port
  input wire logic [15:0] host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [15:0] host_wdata,
  output logic [15:0] host_rdata,
  // Command from the decoder
  input wire logic cmd_valid,
  input wire logic [4:0] cmd_rt_addr,
  input wire logic [4:0] own_rt_addr,
  input wire logic cmd_tx,
  input wire logic [4:0] cmd_subaddr,
  input wire logic [4:0] cmd_count,
  input wire logic cmd_illegal,
  // Decision
  output logic dec_valid,
  output logic dec_accept,
  output logic dec_broadcast,
  output logic dec_mode,
  output logic dec_undefined,
  output logic dec_status_update,
  output logic dec_msg_error,
  output logic dec_send_status,
  output logic dec_send_data,
  output logic dec_bcast_buffer,
  output logic dec_simple_mode,
  output logic [1:0] dec_action,
  // Configuration levels
  output logic single_strobe_byte_read,
  output logic [15:0] second_configuration
);

  ////////////////////////////////////////////////////////////////////////////
  logic [4:0] first_cfg;
  logic undefined_mode_invalid;
  logic broadcast_data_separate;
  logic simple_mode_processing;
  logic broadcast_invalid;

  assign undefined_mode_invalid = first_cfg[`BIT_UMC];
  assign broadcast_data_separate = first_cfg[`BIT_BSEP];
  assign simple_mode_processing = first_cfg[`BIT_SIMPLE_MODE_PROCESSING];
  assign broadcast_invalid = first_cfg[`BIT_BCINV];

  // Soft reset leaves both registers alone; only master reset clears them
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      first_cfg <= 5'(`CFG1_RESET);
    end else if (host_wr && host_addr == `CFG1_ADDR) begin
      first_cfg <= host_wdata[4:0];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      second_configuration <= `CFG2_RESET;
    end else if (host_wr && host_addr == `CFG2_ADDR) begin
      second_configuration <= host_wdata;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      single_strobe_byte_read <= 1'b0;
    end else begin
      single_strobe_byte_read <= first_cfg[`BIT_SSRD];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      host_rdata <= `RDATA_IDLE;
    end else if (host_rd) begin
      case (host_addr)
        `CFG1_ADDR: host_rdata <= {11'h000, first_cfg};
        `CFG2_ADDR: host_rdata <= second_configuration;
        default: host_rdata <= `RDATA_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic is_bcast;
  logic addressed;
  logic is_mode;
  logic undefined;
  logic accept;
  rt_cmd_pkg::action_t action;

  assign is_bcast = cmd_rt_addr == `BCAST_ADDR && !broadcast_invalid;
  assign addressed = cmd_rt_addr == own_rt_addr || is_bcast;
  assign is_mode = cmd_subaddr == `SA_MODE0 || cmd_subaddr == `SA_MODE1;

  always_comb begin
    undefined = 1'b0;
    if (is_mode) begin
      if (!cmd_tx) begin
        undefined = cmd_count <= `MC_TOP_LOW || cmd_count == `MC_16 ||
          cmd_count == `MC_18 || cmd_count == `MC_19;
      end else begin
        undefined = cmd_count == `MC_17 || cmd_count == `MC_20 ||
          cmd_count == `MC_21;
      end
    end
  end

  assign accept = addressed && !(undefined && undefined_mode_invalid);

  always_comb begin
    if (!accept) begin
      action = rt_cmd_pkg::act_ignore;
    end else if (is_mode && cmd_illegal && is_bcast) begin
      action = rt_cmd_pkg::act_error_silent;
    end else if (is_mode && cmd_illegal) begin
      action = rt_cmd_pkg::act_error_status;
    end else begin
      action = rt_cmd_pkg::act_respond;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dec_valid <= 1'b0;
      dec_accept <= 1'b0;
      dec_broadcast <= 1'b0;
      dec_mode <= 1'b0;
      dec_undefined <= 1'b0;
      dec_status_update <= 1'b0;
      dec_msg_error <= 1'b0;
      dec_send_status <= 1'b0;
      dec_send_data <= 1'b0;
      dec_bcast_buffer <= 1'b0;
      dec_simple_mode <= 1'b0;
      dec_action <= 2'h0;
    end else begin
      dec_valid <= cmd_valid;
      dec_accept <= cmd_valid && accept;
      dec_broadcast <= cmd_valid && accept && is_bcast;
      dec_mode <= cmd_valid && is_mode;
      dec_undefined <= cmd_valid && undefined;
      dec_status_update <= cmd_valid && accept;
      dec_msg_error <= cmd_valid &&
        action != rt_cmd_pkg::act_respond &&
        action != rt_cmd_pkg::act_ignore;
      dec_send_status <= cmd_valid && accept && !is_bcast;
      dec_send_data <= cmd_valid && action == rt_cmd_pkg::act_respond &&
        !is_bcast && cmd_tx;
      dec_bcast_buffer <= cmd_valid && accept && is_bcast &&
        broadcast_data_separate;
      dec_simple_mode <= cmd_valid && accept && is_mode &&
        simple_mode_processing;
      dec_action <= cmd_valid ? action : rt_cmd_pkg::act_ignore;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_undef_ignored;
    @(posedge mclk) disable iff (rst)
      cmd_valid && undefined && undefined_mode_invalid |=>
        !dec_accept && !dec_status_update && !dec_send_status;
  endproperty
  a_undef_ignored: assert property (p_undef_ignored)
    else $error("undefined mode code was not ignored");

  property p_undef_valid;
    @(posedge mclk) disable iff (rst)
      cmd_valid && undefined && !undefined_mode_invalid &&
        cmd_rt_addr == own_rt_addr |=> dec_accept && dec_status_update;
  endproperty
  a_undef_valid: assert property (p_undef_valid)
    else $error("undefined mode code not accepted");

  property p_illegal_mode;
    @(posedge mclk) disable iff (rst)
      cmd_valid && accept && is_mode && cmd_illegal && !is_bcast |=>
        dec_msg_error && dec_send_status && !dec_send_data;
  endproperty
  a_illegal_mode: assert property (p_illegal_mode)
    else $error("illegal mode command answered wrongly");

  // A broadcast must never draw a status word, even when in error
  property p_illegal_bcast;
    @(posedge mclk) disable iff (rst)
      cmd_valid && accept && is_mode && cmd_illegal && is_bcast |=>
        dec_msg_error && !dec_send_status &&
        dec_action == rt_cmd_pkg::act_error_silent;
  endproperty
  a_illegal_bcast: assert property (p_illegal_bcast)
    else $error("illegal broadcast mode command answered wrongly");

  property p_bcast_buf;
    @(posedge mclk) disable iff (rst)
      dec_bcast_buffer |-> dec_broadcast && $past(broadcast_data_separate);
  endproperty
  a_bcast_buf: assert property (p_bcast_buf)
    else $error("broadcast buffer chosen without separation");

  property p_simple;
    @(posedge mclk) disable iff (rst)
      cmd_valid && accept && is_mode && simple_mode_processing |=>
        dec_simple_mode;
  endproperty
  a_simple: assert property (p_simple)
    else $error("simplified mode handling not applied");

  property p_undef_code;
    @(posedge mclk) disable iff (rst)
      is_mode && !cmd_tx && cmd_count == `MC_17 |-> !undefined;
  endproperty
  a_undef_code: assert property (p_undef_code)
    else $error("code 17 receive wrongly classed undefined");

  property p_cfg2_soft;
    @(posedge mclk) disable iff (rst)
      soft_reset && !(host_wr && host_addr == `CFG2_ADDR) |=>
        $stable(second_configuration);
  endproperty
  a_cfg2_soft: assert property (p_cfg2_soft)
    else $error("second register changed on soft reset");

  property p_bcast_addr;
    @(posedge mclk) disable iff (rst)
      cmd_valid && cmd_rt_addr == `BCAST_ADDR && !broadcast_invalid &&
        !(undefined && undefined_mode_invalid) |=> dec_broadcast;
  endproperty
  a_bcast_addr: assert property (p_bcast_addr)
    else $error("address 31 not taken as broadcast");

  sequence s_cfg1_write;
    host_wr && host_addr == `CFG1_ADDR ##1 1'b1;
  endsequence

  property p_ssrd;
    @(posedge mclk) disable iff (rst)
      s_cfg1_write |=> single_strobe_byte_read == $past(host_wdata[0], 2);
  endproperty
  a_ssrd: assert property (p_ssrd)
    else $error("single strobe read level wrong");

endmodule // rt_command_validation_config

// file: verilog/rt_cmd_cfg.svh
// Constants for the remote terminal command validation and configuration bank
`ifndef RT_CMD_CFG_SVH
`define RT_CMD_CFG_SVH
`define CFG1_ADDR 16'h0000
`define CFG2_ADDR 16'h0001
`define CFG1_RESET 16'h0000
`define CFG2_RESET 16'h0000
`define RDATA_IDLE 16'h0000
`define BIT_SSRD 0
`define BIT_SIMPLE_MODE_PROCESSING 1
`define BIT_BSEP 2
`define BIT_UMC 3
`define BIT_BCINV 4
`define BCAST_ADDR 5'h1f
`define MC_TOP_LOW 5'h0f
`define MC_16 5'h10
`define MC_17 5'h11
`define MC_18 5'h12
`define MC_19 5'h13
`define MC_20 5'h14
`define MC_21 5'h15
`define SA_MODE0 5'h00
`define SA_MODE1 5'h1f
`endif

// file: verilog/rt_cmd_pkg.sv
// Types for the remote terminal command validation bank
package rt_cmd_pkg;
  typedef enum logic [1:0] {
    act_ignore,
    act_respond,
    act_error_status,
    act_error_silent
  } action_t;
endpackage

// file: verification/bc_model.sv
// Bus controller model that hands command words to the block
`timescale 1ns/1ps
module bc_model (
  // Clock
  input wire logic mclk,
  // Command word
  output logic cmd_valid,
  output logic [4:0] cmd_rt_addr,
  output logic cmd_tx,
  output logic [4:0] cmd_subaddr,
  output logic [4:0] cmd_count,
  output logic cmd_illegal
);
  initial begin
    cmd_valid = 1'b0;
    {cmd_rt_addr, cmd_tx, cmd_subaddr, cmd_count, cmd_illegal} = '0;
  end
  // Called at a clock edge; one command word per cycle
  task automatic issue(input logic bc, tx, input logic [4:0] sa, mc,
                       input logic il);
    #1 cmd_valid = 1'b1;
    cmd_rt_addr = bc ? 5'h1f : 5'h05;
    cmd_tx = tx;
    cmd_subaddr = sa;
    cmd_count = mc;
    cmd_illegal = il;
    @(posedge mclk) cmd_valid <= 1'b0;
    // Stale fields would hide a missing qualifier
    {cmd_rt_addr, cmd_subaddr, cmd_count} <= ~{sa, sa, mc};
  endtask
endmodule // bc_model

// file: verification/tb.sv
// Self-checking bench for the command validation bank
`timescale 1ns/1ps
module tb;
  logic mclk = 1'b0, rst = 1'b1, soft_reset = 1'b0;
  logic host_wr = 1'b0, host_rd = 1'b0, rd_pend = 1'b0;
  logic [15:0] host_addr = 16'h0000, host_wdata = 16'h0000, host_rdata;
  logic [15:0] cfg = 16'h0000, second_configuration;
  logic cmd_valid, cmd_tx, cmd_illegal, dec_valid, dec_accept;
  logic [4:0] cmd_rt_addr, cmd_subaddr, cmd_count;
  logic dec_undefined, dec_msg_error, dec_send_status;
  logic dec_bcast_buffer, dec_simple_mode, single_strobe_byte_read;
  logic dec_broadcast, dec_mode, dec_status_update, dec_send_data;
  logic [1:0] dec_action;
  logic [11:0] dq[$];
  logic [15:0] rq[$];
  int fails = 0, cmp_count = 0;
  always #4 mclk = ~mclk;
  rt_command_validation_config dut (.mclk, .rst, .soft_reset, .host_addr,
    .host_wr, .host_rd, .host_wdata, .host_rdata, .cmd_valid, .cmd_rt_addr,
    .own_rt_addr(5'h05), .cmd_tx, .cmd_subaddr, .cmd_count, .cmd_illegal,
    .dec_valid, .dec_accept, .dec_broadcast, .dec_mode, .dec_undefined,
    .dec_status_update, .dec_msg_error, .dec_send_status, .dec_send_data,
    .dec_bcast_buffer, .dec_simple_mode, .dec_action,
    .single_strobe_byte_read, .second_configuration);
  bc_model bc_i (.mclk, .cmd_valid, .cmd_rt_addr, .cmd_tx, .cmd_subaddr,
    .cmd_count, .cmd_illegal);
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] g, e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, d);
    #1 host_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    @(posedge mclk) host_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, e);
    #1 host_addr = a;
    host_rd = 1'b1;
    rq.push_back(e);
    @(posedge mclk) host_rd <= 1'b0;
  endtask
  task automatic cmd(input logic bc, tx, input logic [4:0] sa, mc,
                     input logic il);
    logic md, un, ok, ad, er;
    logic [1:0] act;
    md = (sa == 5'h00) || (sa == 5'h1f);
    un = md && (tx ? (mc == 5'h11 || mc == 5'h14 || mc == 5'h15)
                   : (mc <= 5'h10 || mc == 5'h12 || mc == 5'h13));
    ad = !(bc && cfg[4]);
    ok = ad && !(un && cfg[3]);
    er = ok && md && il;
    act = !ok ? 2'h0 : er ? (bc ? 2'h3 : 2'h2) : 2'h1;
    // Undefined is a property of the code alone, addressed or not
    dq.push_back({ok, un, er, ok && !bc, ok && bc && cfg[2],
                  ok && md && cfg[1], ok && bc, md, ok,
                  ok && !er && !bc && tx, act});
    bc_i.issue(bc, tx, sa, mc, il && md);
  endtask
  ////////////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    if (dec_valid === 1'b1)
      chk(16'({dec_accept, dec_undefined, dec_msg_error, dec_send_status,
        dec_bcast_buffer, dec_simple_mode, dec_broadcast, dec_mode,
        dec_status_update, dec_send_data, dec_action}),
        dq.size() ? 16'(dq.pop_front()) : 16'hxxxx);
    if (rd_pend)
      chk(host_rdata, rq.size() ? rq.pop_front() : 16'hxxxx);
    rd_pend <= host_rd;
  end
  initial begin
    repeat (50000) @(posedge mclk);
    fails++;
    summarize();
  end
  initial begin
    void'($urandom(32'h9348));
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    rd(16'h0000, 16'h0000);
    rd(16'h0001, 16'h0000);
    wr(16'h0000, 16'h0001);
    @(posedge mclk);
    #1 chk(16'(single_strobe_byte_read), 16'h0001);
    for (int i = 0; i < 32; i++) begin
      cfg = 16'(i);
      wr(16'h0000, 16'hffe0 | cfg);
      rd(16'h0000, cfg);
      repeat (24)
        cmd(1'($urandom), 1'($urandom), 5'($urandom % 3 ?
          ($urandom % 2 ? 5'h1f : 5'h00) : $urandom),
          5'($urandom), 1'($urandom));
    end
    wr(16'h0001, 16'ha5c3);
    wr(16'h0007, 16'h1234);
    rd(16'h0007, 16'h0000);
    #1 soft_reset = 1'b1;
    @(posedge mclk) soft_reset <= 1'b0;
    rd(16'h0001, 16'ha5c3);
    rd(16'h0000, cfg);
    #1 chk(second_configuration, 16'ha5c3);
    repeat (2) @(posedge mclk);
    #1 rst = 1'b1;
    cfg = 16'h0000;
    @(posedge mclk) rst <= 1'b0;
    rd(16'h0000, 16'h0000);
    rd(16'h0001, 16'h0000);
    repeat (2) @(posedge mclk);
    summarize();
  end
endmodule // tb
